// ==== tloc_top.sv ====
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module tloc_top #(
    parameter int UNIT_CYC = tloc_pkg::DELAY_UNIT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // fetched descriptor, one per pulse
    input wire logic desc_valid,
    input wire logic [63:0] desc_lo,
    input wire logic [63:0] desc_hi,
    // write-back and interrupt
    output logic wb_valid,
    output logic [3:0] wb_status,
    output logic [7:0] wb_count,
    output logic tx_int,
    // active context and VLAN mode for the datapath
    output logic seg_on,
    output logic [7:0] ip_sum_start,
    output logic [7:0] ip_sum_offset,
    output logic [15:0] ip_sum_end,
    output logic [7:0] transport_sum_start,
    output logic [7:0] transport_sum_offset,
    output logic [15:0] transport_sum_end,
    output logic ip_v4,
    output logic is_tcp,
    output logic snap_on,
    output logic vlan_mode_enable,
    // packet byte stream
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_last,
    output logic sum_valid,
    output logic [15:0] ip_sum,
    output logic [15:0] transport_sum,
    output logic ip_ins,
    output logic transport_ins,
    output logic pay_done,
    // prototype header read
    input wire logic [7:0] hdr_raddr,
    output logic [7:0] hdr_rdata,
    // segment planner
    input wire logic seg_next,
    output logic frame_valid,
    output logic [15:0] frame_len,
    output logic frame_last
);
    // descriptor decode
    wire [7:0] cmd = desc_hi[tloc_pkg::HI_CMD +: 8];
    wire [3:0] descriptor_type_field = desc_hi[tloc_pkg::HI_DESCRIPTOR_TYPE_FIELD +: 4];
    wire ext = cmd[tloc_pkg::CMD_EXT];
    wire is_ctx = desc_valid & ext & (descriptor_type_field == tloc_pkg::DESCRIPTOR_TYPE_FIELD_CTX);
    wire is_dat = desc_valid & ext & (descriptor_type_field == tloc_pkg::DESCRIPTOR_TYPE_FIELD_DATA);
    wire is_leg = desc_valid & ~ext;
    wire segmentation_enable = cmd[tloc_pkg::CMD_TSE];
    wire rs = desc_valid & cmd[tloc_pkg::CMD_RS];
    wire interrupt_delay_enable = cmd[tloc_pkg::CMD_IDE];
    wire [7:0] popts = desc_hi[tloc_pkg::HI_POPTS +: 8];

    // control and delay registers
    logic [2:0] ctrl_r;
    logic [15:0] delay_r;
    wire wbie = ctrl_r[tloc_pkg::CTRL_WBIE];
    wire burst = ctrl_r[tloc_pkg::CTRL_BURST];

    // stored contexts: index 0 checksum, 1 segmentation
    logic [63:0] ctx_lo_r [2];
    logic [2:0] ctx_flag_r [2]; // snap, ip, tcp
    logic [1:0] ctx_ok_r;
    logic [7:0] prototype_header_length_r;
    logic [15:0] mss_r;
    logic [19:0] total_payload_length_r;

    // per-packet selection from first data descriptor
    logic sop_r;
    logic sel_r;
    logic ipo_r;
    logic tpo_r;

    // delay countdown
    logic [15:0] dly_cnt_r;
    logic [15:0] tick_r;
    logic [7:0] pend_r;

    // byte stream tracking
    logic [19:0] pos_r;
    logic [15:0] ipacc_r;
    logic [15:0] tpacc_r;
    logic [7:0] hdr_mem [256];

    // segment planner
    logic [19:0] rem_r;

    // register writes
    wire wr_ctrl = reg_wr & (reg_addr == tloc_pkg::REG_CTRL);
    wire wr_dly = reg_wr & (reg_addr == tloc_pkg::REG_DELAY);

    // read mux, unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr)
            tloc_pkg::REG_CTRL: rd_mux = {29'h0, ctrl_r};
            tloc_pkg::REG_DELAY: rd_mux = {16'h0, delay_r};
            tloc_pkg::REG_STAT: rd_mux = {dly_cnt_r, pend_r, 5'h0,
                                          sel_r, ctx_ok_r};
            tloc_pkg::REG_SEG: rd_mux = {mss_r, 8'h0, prototype_header_length_r};
            default: rd_mux = 32'h0;
        endcase
    end

    // registers and read data, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= tloc_pkg::CTRL_RST;
            delay_r <= tloc_pkg::DELAY_RST;
            reg_rdata <= 32'h0;
        end else begin
            if (wr_ctrl)
                ctrl_r <= reg_wdata[2:0];
            if (wr_dly)
                delay_r <= reg_wdata[15:0];
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // context load overwrites at once; option bits dropped without tse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctx_ok_r <= 2'h0;
            prototype_header_length_r <= 8'h0;
            mss_r <= 16'h0;
            total_payload_length_r <= 20'h0;
            for (int i = 0; i < 2; i++) begin
                ctx_lo_r[i] <= 64'h0;
                ctx_flag_r[i] <= 3'h0;
            end
        end else if (is_ctx) begin
            ctx_lo_r[segmentation_enable] <= desc_lo;
            ctx_ok_r[segmentation_enable] <= 1'b1;
            if (segmentation_enable) begin
                ctx_flag_r[1] <= {cmd[tloc_pkg::CMD_SNAP],
                                  cmd[tloc_pkg::CMD_IP],
                                  cmd[tloc_pkg::CMD_TCP]};
                prototype_header_length_r <= desc_hi[tloc_pkg::HI_PROTOTYPE_HEADER_LENGTH +: 8];
                mss_r <= desc_hi[tloc_pkg::HI_MSS +: 16];
                total_payload_length_r <= desc_hi[tloc_pkg::HI_TOTAL_PAYLOAD_LENGTH +: 20];
            end else begin
                ctx_flag_r[0] <= 3'h0;
            end
        end
    end

    // first data descriptor of a packet picks context and insert options
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sop_r <= 1'b1;
            sel_r <= 1'b0;
            ipo_r <= 1'b0;
            tpo_r <= 1'b0;
        end else if (is_dat) begin
            if (sop_r) begin
                sel_r <= segmentation_enable;
                ipo_r <= popts[tloc_pkg::OPT_IPINS];
                tpo_r <= popts[tloc_pkg::OPT_TPINS];
            end
            sop_r <= cmd[tloc_pkg::CMD_EOP];
        end
    end

    // active context fields
    wire [63:0] act = ctx_lo_r[sel_r];
    wire [2:0] actf = ctx_flag_r[sel_r];
    wire [7:0] ipss = act[tloc_pkg::LO_IPSS +: 8];
    wire [7:0] ipso = act[tloc_pkg::LO_IPSO +: 8];
    wire [15:0] ipse = act[tloc_pkg::LO_IPSE +: 16];
    wire [7:0] tpss = act[tloc_pkg::LO_TPSS +: 8];
    wire [7:0] tpso = act[tloc_pkg::LO_TPSO +: 8];
    wire [15:0] tpse = act[tloc_pkg::LO_TPSE +: 16];

    // context outputs registered from the active set, VLAN mode from the control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seg_on <= 1'b0;
            ip_sum_start <= 8'h0;
            ip_sum_offset <= 8'h0;
            ip_sum_end <= 16'h0;
            transport_sum_start <= 8'h0;
            transport_sum_offset <= 8'h0;
            transport_sum_end <= 16'h0;
            snap_on <= 1'b0;
            ip_v4 <= 1'b0;
            is_tcp <= 1'b0;
            vlan_mode_enable <= 1'b0;
        end else begin
            seg_on <= sel_r;
            ip_sum_start <= ipss;
            ip_sum_offset <= ipso;
            ip_sum_end <= ipse;
            transport_sum_start <= tpss;
            transport_sum_offset <= tpso;
            transport_sum_end <= tpse;
            {snap_on, ip_v4, is_tcp} <= actf;
            vlan_mode_enable <= ctrl_r[tloc_pkg::VLAN_MODE_ENABLE];
        end
    end

    // interrupt delay: unit tick and countdown
    wire tick = (tick_r == 16'(UNIT_CYC - 1));
    wire expire = tick & (dly_cnt_r == 16'h1);
    wire rs_ide = rs & interrupt_delay_enable;
    wire rs_now = rs & ~interrupt_delay_enable;
    wire zero_ld = rs_ide & (delay_r == 16'h0);
    wire flush = expire | rs_now | zero_ld;

    // countdown reload and clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_r <= 16'h0;
            dly_cnt_r <= 16'h0;
        end else begin
            tick_r <= tick ? 16'h0 : tick_r + 16'h1;
            if (rs_ide)
                dly_cnt_r <= delay_r;
            else if (rs_now)
                dly_cnt_r <= 16'h0;
            else if (tick && dly_cnt_r != 16'h0)
                dly_cnt_r <= dly_cnt_r - 16'h1;
        end
    end

    // write-back and interrupt pulses
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_valid <= 1'b0;
            wb_status <= 4'h0;
            wb_count <= 8'h0;
            pend_r <= 8'h0;
            tx_int <= 1'b0;
        end else begin
            wb_valid <= 1'b0;
            wb_status <= 4'h0;
            wb_count <= 8'h0;
            if (!burst) begin
                wb_valid <= rs;
                wb_status <= rs ? tloc_pkg::STA_DONE : 4'h0;
                wb_count <= {7'h0, rs};
                pend_r <= 8'h0;
            end else if (flush) begin
                wb_valid <= (pend_r != 8'h0) | rs;
                wb_status <= tloc_pkg::STA_DONE;
                wb_count <= pend_r + {7'h0, rs};
                pend_r <= 8'h0;
            end else if (rs) begin
                pend_r <= pend_r + 8'h1;
            end
            tx_int <= wbie & (expire | rs_now | zero_ld);
        end
    end

    // byte stream: range tests and lane selection
    wire [19:0] ip_rel = pos_r - {12'h0, ipss};
    wire [19:0] tp_rel = pos_r - {12'h0, tpss};
    wire in_ip = (pos_r >= {12'h0, ipss}) &
                 ((ipse == 16'h0) | (pos_r <= {4'h0, ipse}));
    wire in_tp = (pos_r >= {12'h0, tpss}) &
                 ((tpse == 16'h0) | (pos_r <= {4'h0, tpse}));
    wire [15:0] ip_w = ip_rel[0] ? {8'h0, byte_data}
                                 : {byte_data, 8'h0};
    wire [15:0] tp_w = tp_rel[0] ? {8'h0, byte_data}
                                 : {byte_data, 8'h0};
    wire [15:0] ip_nx = in_ip ? tloc_pkg::oc_add(ipacc_r, ip_w)
                              : ipacc_r;
    wire [15:0] tp_nx = in_tp ? tloc_pkg::oc_add(tpacc_r, tp_w)
                              : tpacc_r;
    wire [19:0] pay_end = {12'h0, prototype_header_length_r} + total_payload_length_r - 20'h1;

    // sums, position and prototype header capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pos_r <= 20'h0;
            ipacc_r <= 16'h0;
            tpacc_r <= 16'h0;
            sum_valid <= 1'b0;
            ip_sum <= 16'h0;
            transport_sum <= 16'h0;
            ip_ins <= 1'b0;
            transport_ins <= 1'b0;
            pay_done <= 1'b0;
        end else begin
            sum_valid <= 1'b0;
            pay_done <= 1'b0;
            if (byte_valid) begin
                if (sel_r && pos_r < {12'h0, prototype_header_length_r})
                    hdr_mem[pos_r[7:0]] <= byte_data;
                pay_done <= sel_r & (pos_r == pay_end);
                if (byte_last) begin
                    pos_r <= 20'h0;
                    ipacc_r <= 16'h0;
                    tpacc_r <= 16'h0;
                    sum_valid <= 1'b1;
                    ip_sum <= ~ip_nx;
                    transport_sum <= ~tp_nx;
                    ip_ins <= ipo_r & ({12'h0, ipso} < pos_r);
                    transport_ins <= tpo_r &
                                     ({12'h0, tpso} < pos_r);
                end else begin
                    pos_r <= pos_r + 20'h1;
                    ipacc_r <= ip_nx;
                    tpacc_r <= tp_nx;
                end
            end
        end
    end

    // prototype header read port
    always_ff @(posedge ref_clk) begin
        if (rst)
            hdr_rdata <= 8'h0;
        else
            hdr_rdata <= hdr_mem[hdr_raddr];
    end

    // segment planner: each frame is min(rest, mss) plus header
    wire last_fr = rem_r <= {4'h0, mss_r};
    wire [19:0] take = last_fr ? rem_r : {4'h0, mss_r};
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rem_r <= 20'h0;
            frame_valid <= 1'b0;
            frame_len <= 16'h0;
            frame_last <= 1'b0;
        end else begin
            frame_valid <= 1'b0;
            if (is_ctx && segmentation_enable)
                rem_r <= desc_hi[tloc_pkg::HI_TOTAL_PAYLOAD_LENGTH +: 20];
            else if (seg_next && sel_r && rem_r != 20'h0) begin
                rem_r <= rem_r - take;
                frame_valid <= 1'b1;
                frame_len <= take[15:0] + {8'h0, prototype_header_length_r};
                frame_last <= last_fr;
            end
        end
    end

    // legacy descriptors only take part in write-back, interrupt and delay countdown
    wire unused_ok = is_leg;
endmodule

// ==== tloc_pkg.sv ====
// What this block does
// - extension 1 and type 0 means context
// - sum start byte offset, zero first byte
// - sum offset places result, skip past length
// - sixteen-bit sum end, zero means end
// - transport fields follow the same meaning
// - segmentation uses start fields as header starts
// - frames carry segment size plus header
// - first header bytes kept as prototype
// - payload length counts data after header
// - command byte bit meanings decoded
// - only delay, extension, report kept without segmentation
// - report with delay reloads the countdown
// - report alone interrupts now, clears countdown
// - write-back not delayed unless bursting
// - done bit only for report descriptors
// - SNAP bit marks header for update
// - context load overwrites the stored set
// - IP bit picks v4/v6, TCP picks TCP/UDP
// - insert options decide checksum replacement
package tloc_pkg;
    // descriptor type codes
    localparam logic [3:0] DESCRIPTOR_TYPE_FIELD_CTX = 4'h0;
    localparam logic [3:0] DESCRIPTOR_TYPE_FIELD_DATA = 4'h1;
    // first quadword field positions
    localparam int LO_IPSS = 0;
    localparam int LO_IPSO = 8;
    localparam int LO_IPSE = 16;
    localparam int LO_TPSS = 32;
    localparam int LO_TPSO = 40;
    localparam int LO_TPSE = 48;
    // second quadword field positions
    localparam int HI_TOTAL_PAYLOAD_LENGTH = 0;
    localparam int HI_DESCRIPTOR_TYPE_FIELD = 20;
    localparam int HI_CMD = 24;
    localparam int HI_PROTOTYPE_HEADER_LENGTH = 40;
    localparam int HI_POPTS = 40;
    localparam int HI_MSS = 48;
    // command byte bits
    localparam int CMD_IDE = 7;
    localparam int CMD_SNAP = 6;
    localparam int CMD_EXT = 5;
    localparam int CMD_RS = 3;
    localparam int CMD_TSE = 2;
    localparam int CMD_IP = 1;
    localparam int CMD_TCP = 0;
    localparam int CMD_EOP = 0;
    // packet option bits
    localparam int OPT_IPINS = 0;
    localparam int OPT_TPINS = 1;
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DELAY = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_SEG = 8'h0c;
    // control bits
    localparam int CTRL_WBIE = 0;
    localparam int CTRL_BURST = 1;
    localparam int VLAN_MODE_ENABLE = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] DELAY_RST = 16'h0000;
    localparam logic [3:0] STA_DONE = 4'h1;
    // delay unit timing
    localparam int DELAY_UNIT_NS = 1024;
    localparam int CLK_NS = 8;
    localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_NS;

    // end-around-carry sixteen-bit add
    function automatic logic [15:0] oc_add(input logic [15:0] a,
                                           input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        oc_add = s[15:0] + {15'h0000, s[16]};
    endfunction
endpackage

// ==== tloc_monitor.sv ====
`timescale 1ns/1ns
// watches write-back, context and planner timing at the loader's ports
module tloc_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic desc_valid,
    input wire logic [63:0] desc_lo,
    input wire logic [63:0] desc_hi,
    input wire logic wb_valid,
    input wire logic [3:0] wb_status,
    input wire logic tx_int,
    input wire logic seg_on,
    input wire logic [15:0] ip_sum_end,
    input wire logic [7:0] transport_sum_start,
    input wire logic ip_v4,
    input wire logic is_tcp,
    input wire logic snap_on,
    input wire logic byte_valid,
    input wire logic byte_last,
    input wire logic sum_valid,
    input wire logic seg_next,
    input wire logic frame_valid,
    input wire logic [15:0] frame_len,
    input wire logic frame_last
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic wbie_r, burst_r; // mirrored control bits
    logic [15:0] mss_r; // stored segment size
    logic [7:0] hdr_r; // stored header length
    // descriptor decode
    wire ctx_w = desc_valid && desc_hi[29] && desc_hi[23:20] == 4'h0;
    wire rs_w = desc_hi[27];
    wire ide_w = desc_hi[31];
    wire tse_w = desc_hi[26];
    // follow control writes and segmentation loads
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wbie_r <= 1'b0;
            burst_r <= 1'b0;
            mss_r <= 16'h0000;
            hdr_r <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == tloc_pkg::REG_CTRL) begin
                wbie_r <= reg_wdata[0];
                burst_r <= reg_wdata[1];
            end
            if (ctx_w && tse_w) begin
                mss_r <= desc_hi[63:48];
                hdr_r <= desc_hi[47:40];
            end
        end
    end
    // a context load followed by a quiet cycle
    sequence sum_load;
        ctx_w && !tse_w ##1 !desc_valid;
    endsequence
    sequence seg_load;
        ctx_w && tse_w ##1 !desc_valid;
    endsequence
    a_sum_fields: assert property (sum_load |=> seg_on ||
        (ip_sum_end == $past(desc_lo[31:16], 2) &&
        transport_sum_start == $past(desc_lo[39:32], 2)))
        else $error("checksum context fields not loaded");
    a_seg_opts: assert property (seg_load |=> !seg_on ||
        (snap_on == $past(desc_hi[30], 2) &&
        ip_v4 == $past(desc_hi[25], 2) && is_tcp == $past(desc_hi[24], 2)))
        else $error("segmentation option bits not loaded");
    a_sum_opts: assert property (
        !seg_on |-> !snap_on && !ip_v4 && !is_tcp)
        else $error("option bits seen in checksum context");
    a_wb_report: assert property (
        desc_valid && rs_w && !burst_r |=> wb_valid && wb_status[0])
        else $error("write-back missing after report descriptor");
    a_wb_silent: assert property (
        desc_valid && !rs_w && !burst_r |=> !wb_valid)
        else $error("write-back without report");
    a_int_now: assert property (
        desc_valid && rs_w && !ide_w && wbie_r && !burst_r |=> tx_int)
        else $error("immediate interrupt missing");
    a_int_off: assert property (
        !wbie_r && !$past(wbie_r) |-> !tx_int)
        else $error("interrupt while disabled");
    a_sum_time: assert property (
        byte_valid && byte_last |=> sum_valid)
        else $error("sum not ready after last byte");
    a_frame_time: assert property (seg_next |=> frame_valid)
        else $error("frame plan late");
    a_frame_len: assert property (
        frame_valid && !frame_last |-> frame_len == mss_r + {8'h00, hdr_r})
        else $error("inner frame length wrong");
endmodule

bind tloc_top tloc_monitor u_mon (.*);

// ==== tloc_host.sv ====
`timescale 1ns/1ns
// host side: hands one ring entry to the loader per request
module tloc_host (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [63:0] lo_in,
    input wire logic [63:0] hi_in,
    output logic desc_valid = 1'b0,
    output logic [63:0] desc_lo = 64'h0,
    output logic [63:0] desc_hi = 64'h0
);
    // entries are laid out legally by the bench
    // between entries the words flip so stale data never looks held
    always_ff @(posedge ref_clk) begin
        desc_valid <= go;
        if (go) begin
            desc_lo <= lo_in;
            desc_hi <= hi_in;
        end else begin
            desc_lo <= ~desc_lo;
            desc_hi <= ~desc_hi;
        end
    end
endmodule

// ==== tloc_bench.sv ====
`timescale 1ns/1ns
// self-checking bench for the context loader
module tloc_bench;
    localparam int UC = 4; // short delay unit
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, seg_next = 1'b0;
    logic byte_valid = 1'b0, byte_last = 1'b0;
    logic [7:0] reg_addr = 8'h00, byte_data = 8'h00, hdr_raddr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic desc_valid, wb_valid, tx_int, seg_on, ip_v4, is_tcp, snap_on;
    logic vlan_mode_enable, sum_valid, ip_ins, transport_ins, pay_done;
    logic frame_valid, frame_last;
    logic [63:0] desc_lo, desc_hi, lo_in = 64'h0, hi_in = 64'h0;
    logic [3:0] wb_status;
    logic [7:0] wb_count, ip_sum_start, ip_sum_offset, hdr_rdata;
    logic [7:0] transport_sum_start, transport_sum_offset;
    logic [15:0] ip_sum_end, transport_sum_end, ip_sum, transport_sum;
    logic [15:0] frame_len;
    logic [7:0] cmds [3] = '{8'h28, 8'h20, 8'ha0}; // command table
    logic [7:0] tso [2] = '{8'h14, 8'hf0}; // in and past the packet
    int bad_count = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h00014d48; // random source state
    logic [7:0] pkt [$]; // packet bytes of the model
    tloc_top #(.UNIT_CYC(UC)) uut (.*);
    tloc_host host (.*);
    always #4 ref_clk = ~ref_clk;
    // shift-register random source
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // second quadword with command and type
    function automatic logic [63:0] hw(input logic [7:0] c,
                                       input logic [3:0] t,
                                       input logic [63:0] u);
        return u | {32'h0, c, t, 20'h0};
    endfunction
    // ones-complement sum model, end zero means last byte
    function automatic logic [15:0] osum(input int s, input int e);
        int acc;
        acc = 0;
        if (e == 0) e = pkt.size() - 1;
        for (int i = s; i <= e; i++)
            acc += ((i - s) % 2 == 0) ? int'(pkt[i]) * 256 : int'(pkt[i]);
        while (acc > 32'hffff) acc = (acc & 32'hffff) + (acc >> 16);
        return ~acc[15:0];
    endfunction
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic results();
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // register read and compare
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, exp);
    endtask
    // one descriptor, returns in the write-back cycle
    task automatic send(input logic [63:0] lo, input logic [63:0] hi);
        @(posedge ref_clk);
        lo_in <= lo;
        hi_in <= hi;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    // random packet streamed, returns in the sum cycle
    task automatic stream(input int n);
        logic [31:0] r;
        pkt.delete();
        repeat (n) begin
            r = rnd();
            pkt.push_back(r[7:0]);
        end
        pkt[10] = 8'h00; // zero preload of the ip field
        pkt[11] = 8'h00;
        foreach (pkt[i]) begin
            @(posedge ref_clk);
            byte_valid <= 1'b1;
            byte_data <= pkt[i];
            byte_last <= (i == n - 1);
        end
        @(posedge ref_clk);
        byte_valid <= 1'b0;
        byte_last <= 1'b0;
        @(negedge ref_clk);
    endtask
    // watchdog
    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        results();
    end
    // main sequence
    initial begin
        logic [31:0] r;
        logic [7:0] ipss, tpss, hl;
        logic [63:0] lo;
        int cnt, rem, ln;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd(tloc_pkg::REG_CTRL, 32'h0);
        rd(8'h40, 32'h0);
        // report with interrupts still off
        send(64'h0, hw(8'h28, 4'h0, 64'h0));
        check({wb_valid, wb_status, wb_count, tx_int}, 14'h2202);
        wr(tloc_pkg::REG_CTRL, 32'h5);
        wr(tloc_pkg::REG_DELAY, 32'h3);
        rd(tloc_pkg::REG_DELAY, 32'h3);
        check(vlan_mode_enable, 1'b1);
        for (int k = 0; k < 3; k++) begin
            send(64'h0, hw(cmds[k], 4'h0, 64'h0));
            check({wb_valid, tx_int},
                  {cmds[k][3], cmds[k][3] & ~cmds[k][7]});
        end
        cnt = 0;
        repeat (3 * UC + 4) begin
            @(negedge ref_clk);
            cnt += tx_int;
        end
        check(cnt, 0);
        // delayed interrupt, reloaded mid-count
        send(64'h0, hw(8'ha8, 4'h0, 64'h0));
        check({wb_valid, tx_int}, 2'b10);
        repeat (4) @(negedge ref_clk);
        send(64'h0, hw(8'ha8, 4'h0, 64'h0));
        cnt = 0;
        while (!tx_int && cnt < 100) begin
            @(negedge ref_clk);
            cnt++;
        end
        // unit prescaler runs free, so the first unit may be partial
        check(cnt >= 2 * UC + 1 && cnt <= 3 * UC, 1'b1);
        // checksum contexts, option bits must be dropped
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            ipss = {5'h00, r[2:0]};
            tpss = 8'h14 + {5'h00, r[10:8]};
            lo = {16'h0000, tso[k], tpss, 16'h001d, 8'h0a, ipss};
            send(lo, hw(8'h63, 4'h0, 64'h0));
            @(negedge ref_clk);
            check({ip_sum_start, ip_sum_offset, ip_sum_end},
                  {lo[7:0], lo[15:8], lo[31:16]});
            check({transport_sum_start, transport_sum_offset,
                   transport_sum_end},
                  {lo[39:32], lo[47:40], lo[63:48]});
            check({seg_on, snap_on, ip_v4, is_tcp}, 4'h0);
            send(~lo, hw(8'h03, 4'h0, 64'h0));
            @(negedge ref_clk);
            check(ip_sum_start, ipss);
            send(64'h0, hw(8'h21, 4'h1, 64'h0000_0300_0000_0028));
            stream(40);
            check({sum_valid, ip_ins, transport_ins},
                  {2'b11, tso[k] < 39});
            check(ip_sum, osum(ipss, 29));
            check(transport_sum, osum(tpss, 0));
        end
        // segmentation context with legal sizes
        r = rnd();
        hl = 8'h14 + {5'h00, r[2:0]};
        lo = {16'h0000, 8'h32, 8'h22, 16'h0000, 8'h18, 8'h0e};
        // packet selects the segmentation set, then the set is loaded
        send(64'h0, hw(8'h25, 4'h1, 64'h0000_0300_0000_0000));
        send(lo, hw(8'h67, 4'h0, {16'h0020, hl, 20'h0, 20'h00046}));
        @(negedge ref_clk);
        check({seg_on, snap_on, ip_v4, is_tcp}, 4'hf);
        rd(tloc_pkg::REG_SEG, {16'h0020, 8'h00, hl});
        stream(int'(hl) + 70);
        check({sum_valid, pay_done}, 2'b11);
        for (int k = 0; k < 4; k++) begin
            r = rnd() % hl;
            @(posedge ref_clk);
            hdr_raddr <= r[7:0];
            @(posedge ref_clk);
            @(negedge ref_clk);
            check(hdr_rdata, pkt[r]);
        end
        rem = 70;
        while (rem > 0) begin
            @(posedge ref_clk);
            seg_next <= 1'b1;
            @(posedge ref_clk);
            seg_next <= 1'b0;
            @(negedge ref_clk);
            ln = rem > 32 ? 32 : rem;
            rem -= ln;
            check({frame_valid, frame_last, frame_len},
                  {1'b1, rem == 0, 16'(ln + hl)});
        end
        // write-back bursting holds two delayed reports until a flush
        wr(tloc_pkg::REG_CTRL, 32'h7);
        for (int k = 0; k < 3; k++) begin
            send(64'h0, hw(k < 2 ? 8'ha8 : 8'h28, 4'h0, 64'h0));
            check({wb_valid, wb_count, tx_int},
                  k < 2 ? 10'h000 : 10'h207);
        end
        results();
    end
endmodule
